// *** utsbg_top.sv ***
// Notes on behaviour
// - writing the holding buffer sets buffer-full
// - move to shifter or disable clears buffer-full
// - load into shifter sets shift-busy
// - frame end without reload, or disable, clears busy
// - status read only: bit1 full, bit0 busy
// - status zero after reset and while disabled
// - select fx over 2^n, or timer output
// - clock select resets zero, upper nibble zero
// - divide base clock by k, 8 to 255
// - bit rate is divider output halved
// - divisor register resets to FFH
// - same-value rewrite never disturbs running traffic
// - power off stops clocks, resets, line high
// - divider output active on second base clock
// - transmit enable low resets transmit side only
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module utsbg_top
    import utsbg_pkg::*;
#(
    parameter int DIV_W  = 8,   // divisor width
    parameter int DATA_W = 8    // character width
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [UTSBG_AW-1:0] paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic                timer_out,            // eight bit timer output, async
    output logic                     serial_transmit_pin,  // idles high
    output logic                     bit_clock             // halved divider output
);

    // byte address of a register index
    function automatic logic [UTSBG_AW-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // tick when the low n prescaler bits are all ones
    function automatic logic pow_tick(input logic [UTSBG_PRESCALE_W-1:0] pre,
                                      input logic [3:0] n);
        logic [UTSBG_PRESCALE_W-1:0] mask;
        mask     = '0;
        mask     = UTSBG_PRESCALE_W'((11'h001 << n) - 11'h001);
        pow_tick = ((pre & mask) == mask);
    endfunction

    typedef enum logic {
        TX_IDLE,
        TX_SHIFT
    } utsbg_tx_state_t;

    // ---------------- registers ----------------
    logic [7:0]              mode_reg;        // power, transmit and receive enables
    logic [3:0]              cksel;           // base clock select, low nibble only
    logic [DIV_W-1:0]        divisor;         // baud divisor k
    logic [DATA_W-1:0]       tx_holding_buffer;
    utsbg_txflags_t          flags;           // buffer full / shift busy
    logic                    buf_full;        // holding buffer has data
    logic                    shift_busy;      // shifter is sending a frame
    utsbg_tx_state_t         tx_state;        // transmit sequencer
    logic [DATA_W:0]         tx_shift_register; // data then stop bit
    logic [3:0]              bits_left;       // bit times left in frame
    logic [UTSBG_PRESCALE_W-1:0] prescale;    // free running power of two divider
    logic                    timer_s1;        // timer synchroniser first stage
    logic                    timer_s2;        // timer synchroniser second stage
    logic                    timer_prev;      // for rising edge of synced timer
    logic                    bit_tick;        // one pulse per bit time
    logic                    div_level;       // toggle stage from divider

    // ---------------- decoding ----------------
    // one driver per carrier, so no struct is written from two places
    utsbg_mode_t mode;
    assign mode  = {mode_reg[UTSBG_MODE_POWER_BIT], mode_reg[UTSBG_MODE_TXE_BIT],
                    mode_reg[UTSBG_MODE_RXE_BIT]};
    assign flags = {buf_full, shift_busy};

    // transmit side runs only while both bits are set
    wire logic tx_on = mode.power & mode.txe;

    // apb phases; pready is a flop so accesses take one wait-free access cycle
    wire logic setup_ph = psel & ~penable;
    wire logic access   = psel & penable & pready;
    wire logic wr_en    = access & pwrite;

    wire logic hit_mode   = (paddr == reg_addr(UTSBG_IDX_MODE));
    wire logic hit_txbuf  = (paddr == reg_addr(UTSBG_IDX_TXBUF));
    wire logic hit_status = (paddr == reg_addr(UTSBG_IDX_STATUS));
    wire logic hit_cksel  = (paddr == reg_addr(UTSBG_IDX_CKSEL));
    wire logic hit_div    = (paddr == reg_addr(UTSBG_IDX_DIV));
    wire logic hit_any    = hit_mode | hit_txbuf | hit_status | hit_cksel | hit_div;

    // status byte: upper six bits always zero
    wire logic [7:0] status_byte = {6'h00, flags.buf_full, flags.shift_busy};

    // read mux; the holding buffer is write only and reads zero
    wire logic [7:0] rd_byte =
        hit_mode   ? {mode_reg[7:5], 5'h00} :
        hit_status ? status_byte :
        hit_cksel  ? {4'h0, cksel} :
        hit_div    ? 8'(divisor) : 8'h00;

    // writes to the status register are dropped without error
    wire logic buf_write = wr_en & hit_txbuf & tx_on;

    // ---------------- base clock ----------------
    wire logic timer_rise = timer_s2 & ~timer_prev;

    // prohibited codes give no base clock at all
    wire logic base_tick =
        (cksel <= UTSBG_CKSEL_MAX_POW) ? pow_tick(prescale, cksel) :
        (cksel == UTSBG_CKSEL_TIMER)   ? timer_rise : 1'b0;

    // ---------------- transmit sequencer decisions ----------------
    wire logic frame_end = bit_tick & (tx_state == TX_SHIFT) &
                           (bits_left == UTSBG_FRAME_LAST);
    // a byte moves over on a bit boundary when the shifter is free or just finished
    wire logic load_now  = tx_on & flags.buf_full & bit_tick &
                           ((tx_state == TX_IDLE) | frame_end);

    // ---------------- apb slave ----------------
    // pready rises for the access phase that follows each setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit_any;   // unmapped address answers with error
        end
    end

    // read data captured in setup so it comes from a flop during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // mode register; power and enable bits are plain control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= UTSBG_MODE_RESET;
        end else if (wr_en && hit_mode) begin
            mode_reg <= {pwdata[7:5], 5'h00};
        end
    end

    // clock select; only the low nibble is stored so the top reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cksel <= UTSBG_CKSEL_RESET;
        end else if (wr_en && hit_cksel) begin
            cksel <= pwdata[3:0];
        end
    end

    // divisor; same-value rewrite changes nothing downstream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor <= DIV_W'(UTSBG_DIV_RESET);
        end else if (wr_en && hit_div) begin
            divisor <= pwdata[DIV_W-1:0];
        end
    end

    // holding buffer data; overwrite while full is the caller's hazard
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_holding_buffer <= DATA_W'(UTSBG_TXBUF_RESET);
        end else if (buf_write) begin
            tx_holding_buffer <= pwdata[DATA_W-1:0];
        end
    end

    // ---------------- base clock generation ----------------
    // prescaler frozen and cleared while unpowered, so the fx/2^n ticks for n of 1 to 10 stop; fx/2^0 and the timer keep ticking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else if (!mode.power) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + UTSBG_PRESCALE_W'(1);
        end
    end

    // timer output comes from elsewhere; two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_s1   <= 1'b0;
            timer_s2   <= 1'b0;
            timer_prev <= 1'b0;
        end else begin
            timer_s1   <= timer_out;
            timer_s2   <= timer_s1;
            timer_prev <= timer_s2;
        end
    end

    // divider and toggle stage
    utsbg_baud_div #(
        .DIV_W     (DIV_W)
    ) u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (mode.power),
        .base_tick (base_tick),
        .divisor   (divisor),
        .bit_tick  (bit_tick),
        .bit_clock (div_level)
    );

    // bit clock level brought out through a flop of its own
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_clock <= 1'b0;
        end else begin
            bit_clock <= div_level;
        end
    end

    // ---------------- buffer-full flag ----------------
    // a write in the same cycle as a move-over keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_full <= 1'b0;
        end else if (!tx_on) begin
            buf_full <= 1'b0;
        end else if (buf_write) begin
            buf_full <= 1'b1;
        end else if (load_now) begin
            buf_full <= 1'b0;
        end
    end

    // ---------------- transmit sequencer ----------------
    // start bit goes out on the loading tick, so frames abut
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state          <= TX_IDLE;
            shift_busy        <= 1'b0;
            tx_shift_register <= '1;
            bits_left         <= 4'h0;
        end else if (!tx_on) begin
            tx_state          <= TX_IDLE;
            shift_busy        <= 1'b0;
            tx_shift_register <= '1;
            bits_left         <= 4'h0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (load_now) begin
                        tx_state          <= TX_SHIFT;
                        shift_busy        <= 1'b1;
                        tx_shift_register <= {1'b1, tx_holding_buffer};
                        bits_left         <= UTSBG_FRAME_LOAD;
                    end
                end
                TX_SHIFT: begin
                    if (load_now) begin
                        // back to back: next frame starts right away
                        shift_busy        <= 1'b1;
                        tx_shift_register <= {1'b1, tx_holding_buffer};
                        bits_left         <= UTSBG_FRAME_LOAD;
                    end else if (frame_end) begin
                        tx_state          <= TX_IDLE;
                        shift_busy        <= 1'b0;
                        bits_left         <= 4'h0;
                    end else if (bit_tick) begin
                        tx_shift_register <= {1'b1, tx_shift_register[DATA_W:1]};
                        bits_left         <= bits_left - 4'h1;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // ---------------- line driver ----------------
    // line is high whenever unpowered or disabled; lsb first after start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_transmit_pin <= 1'b1;
        end else if (!tx_on) begin
            serial_transmit_pin <= 1'b1;
        end else if (load_now) begin
            serial_transmit_pin <= 1'b0;                  // start bit
        end else if (frame_end) begin
            serial_transmit_pin <= 1'b1;                  // idle after stop
        end else if (bit_tick && tx_state == TX_SHIFT) begin
            serial_transmit_pin <= tx_shift_register[0];
        end
    end

endmodule : utsbg_top
`default_nettype wire

// *** utsbg_pkg.sv ***
// shared constants and carriers for the transmit status and baud generator
`default_nettype none
package utsbg_pkg;

    // register indices (byte address is four times the index)
    localparam logic [15:0] UTSBG_IDX_MODE   = 16'hFF50; // power / enables
    localparam logic [15:0] UTSBG_IDX_TXBUF  = 16'hFF54; // transmit holding buffer
    localparam logic [15:0] UTSBG_IDX_STATUS = 16'hFF55; // transmit status, read only
    localparam logic [15:0] UTSBG_IDX_CKSEL  = 16'hFF56; // base clock select
    localparam logic [15:0] UTSBG_IDX_DIV    = 16'hFF57; // baud divisor

    // apb address width, enough for index times four
    localparam int          UTSBG_AW = 18;

    // mode register field positions
    localparam int          UTSBG_MODE_POWER_BIT = 7;
    localparam int          UTSBG_MODE_TXE_BIT   = 6;
    localparam int          UTSBG_MODE_RXE_BIT   = 5;

    // status register field positions
    localparam int          UTSBG_STAT_BUF_BIT   = 1;
    localparam int          UTSBG_STAT_SHIFT_BIT = 0;

    // reset values
    localparam logic [7:0]  UTSBG_MODE_RESET   = 8'h00;
    localparam logic [3:0]  UTSBG_CKSEL_RESET  = 4'h0;
    localparam logic [7:0]  UTSBG_DIV_RESET    = 8'hFF;
    localparam logic [7:0]  UTSBG_TXBUF_RESET  = 8'h00;

    // base clock select codes
    localparam logic [3:0]  UTSBG_CKSEL_MAX_POW = 4'hA; // fx / 2^10
    localparam logic [3:0]  UTSBG_CKSEL_TIMER   = 4'hB; // eight bit timer output
    localparam int          UTSBG_PRESCALE_W    = 10;

    // divisor limits and frame timing
    localparam logic [7:0]  UTSBG_DIV_MIN       = 8'h08;
    localparam logic [1:0]  UTSBG_START_TICKS   = 2'h2; // base clocks before divider runs
    localparam logic [3:0]  UTSBG_FRAME_LOAD    = 4'hA; // bit times of start, data bits and stop
    localparam logic [3:0]  UTSBG_FRAME_LAST    = 4'h1; // tick that ends the stop bit

    // control bits from the mode register
    typedef struct packed {
        logic power;
        logic txe;
        logic rxe;
    } utsbg_mode_t;

    // transmit pipeline flags
    typedef struct packed {
        logic buf_full;
        logic shift_busy;
    } utsbg_txflags_t;

endpackage : utsbg_pkg
`default_nettype wire

// *** utsbg_baud_div.sv ***
`timescale 1ns/1ps
`default_nettype none
// programmable divider of the selected base clock, halved into the bit clock
module utsbg_baud_div
    import utsbg_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,        // power on
    input  wire logic             base_tick,  // one cycle per base clock
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  bit_tick,   // one pulse per serial bit
    output logic                  bit_clock   // halved divider output level
);

    logic [DIV_W-1:0] count;       // base clocks counted so far
    logic [1:0]       start_cnt;   // base clocks seen since power up
    logic             half;        // toggle stage

    // divider stays parked on prohibited divisors
    wire logic div_ok   = (divisor >= DIV_W'(UTSBG_DIV_MIN));
    wire logic active   = (start_cnt == UTSBG_START_TICKS);
    wire logic div_wrap = run & active & div_ok & base_tick &
                          (count == divisor - DIV_W'(1));

    // start delay after the power bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cnt <= 2'h0;
        end else if (!run) begin
            start_cnt <= 2'h0;
        end else if (base_tick && !active) begin
            start_cnt <= start_cnt + 2'h1;
        end
    end

    // count 0 .. k-1, wrap and pulse; rewriting the same k leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!run || !active || !div_ok) begin
            count <= '0;
        end else if (div_wrap) begin
            count <= '0;
        end else if (base_tick) begin
            count <= count + DIV_W'(1);
        end
    end

    // toggle stage halves the divider rate into the bit clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half     <= 1'b0;
            bit_tick <= 1'b0;
        end else if (!run) begin
            half     <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            half     <= half ^ div_wrap;
            bit_tick <= div_wrap & half;
        end
    end

    assign bit_clock = half;

endmodule : utsbg_baud_div
`default_nettype wire

// *** utsbg_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the top ports only; cksel 0 and divisor 8 give 16 pclk per bit
module utsbg_top_asserts
    import utsbg_pkg::*;
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [UTSBG_AW-1:0] paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr,
    input wire logic                timer_out,
    input wire logic                serial_transmit_pin,
    input wire logic                bit_clock
);
    localparam logic [UTSBG_AW-1:0] A_MODE = {UTSBG_IDX_MODE, 2'h0};
    localparam logic [UTSBG_AW-1:0] A_STAT = {UTSBG_IDX_STATUS, 2'h0};
    // decoded views of the bus
    wire logic acc    = psel && penable && pready;    // completing transfer
    wire logic is_st  = (paddr == A_STAT);            // status address
    wire logic off_wr = acc && pwrite && (paddr == A_MODE) && !pwdata[UTSBG_MODE_POWER_BIT];
    wire logic mapped = (paddr == A_MODE) || is_st || (paddr == {UTSBG_IDX_TXBUF, 2'h0})
                     || (paddr == {UTSBG_IDX_CKSEL, 2'h0}) || (paddr == {UTSBG_IDX_DIV, 2'h0});

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a low run on the line lasts at least half a bit at 16 pclk per bit, never a glitch
    sequence s_line_fall;
        $fell(serial_transmit_pin);
    endsequence
    // the halved divider output lasts at least k base clocks
    sequence s_bclk_fall;
        $fell(bit_clock);
    endsequence

    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("unmapped access without error");
    a_status_no_err: assert property (acc && is_st |-> !pslverr)
        else $error("status access flagged as error");
    a_status_upper: assert property (acc && !pwrite && is_st |-> prdata[31:2] == 30'h0)
        else $error("status upper bits not zero");
    a_off_line_high: assert property (off_wr |=> ##1 serial_transmit_pin [*4])
        else $error("line not high after power off");
    a_off_bclk_stop: assert property (off_wr |=> ##3 $stable(bit_clock) [*8])
        else $error("bit clock runs while unpowered");
    a_bit_width: assert property (s_line_fall |=> !serial_transmit_pin [*8])
        else $error("line low run too short");
    a_bclk_half: assert property (s_bclk_fall |=> $stable(bit_clock) [*7])
        else $error("bit clock half period too short");
endmodule // utsbg_top_asserts

bind utsbg_top utsbg_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timer_out(timer_out),
    .serial_transmit_pin(serial_transmit_pin), .bit_clock(bit_clock));
`default_nettype wire

// *** utsbg_line_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// remote receiver on the line: 8N1, lsb first, samples mid bit
module utsbg_line_peer #(
    parameter int BIT_CYC = 16     // pclk per bit at the chosen baud
) (
    input  wire logic pclk,
    input  wire logic line,
    output logic [7:0] rx_data,    // last byte received
    output logic [7:0] rx_count,   // frames received
    output logic       rx_err      // stop bit missing
);
    logic [7:0] sh;                // assembly register
    int         i;                 // bit index
    // behavioural only; a start that is gone at mid bit is a glitch
    initial begin
        rx_data = 8'h00;
        rx_count = 8'h00;
        rx_err = 1'b0;
        forever begin
            @(negedge line);
            repeat (BIT_CYC / 2) @(posedge pclk);
            if (line === 1'b0) begin
                for (i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge pclk);
                    sh[i] = line;
                end
                repeat (BIT_CYC) @(posedge pclk);
                if (line !== 1'b1) rx_err = 1'b1;
                rx_data = sh;
                rx_count = rx_count + 8'h01;
            end
        end
    end
endmodule // utsbg_line_peer
`default_nettype wire

// *** test_uart_tx_status_and_baud_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module test_uart_tx_status_and_baud_gen
    import utsbg_pkg::*;
;
    localparam logic [UTSBG_AW-1:0] A_MODE = {UTSBG_IDX_MODE, 2'h0};
    localparam logic [UTSBG_AW-1:0] A_TXB  = {UTSBG_IDX_TXBUF, 2'h0};
    localparam logic [UTSBG_AW-1:0] A_STAT = {UTSBG_IDX_STATUS, 2'h0};
    localparam logic [UTSBG_AW-1:0] A_CKS  = {UTSBG_IDX_CKSEL, 2'h0};
    localparam logic [UTSBG_AW-1:0] A_DIV  = {UTSBG_IDX_DIV, 2'h0};
    localparam logic [UTSBG_AW-1:0] A_NONE = 18'h3FD64;  // hole in the map
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [UTSBG_AW-1:0] paddr = '0;
    logic [31:0]         pwdata = 32'h0;
    logic                timer_out = 1'b0;
    logic [2:0]          tdiv = 3'h0;  // timer stand-in prescaler
    logic [31:0]         rdv;          // last read data
    logic                err;          // last error response
    wire logic           pready, pslverr, line, bclk, rx_err;
    wire logic [31:0]    prdata;
    wire logic [7:0]     rx_data, rx_count;
    int                  n_mismatch = 0;
    int                  compares = 0;

    always #25 pclk = ~pclk;
    // timer already running with square output, period 8 pclk
    always @(posedge pclk) begin
        tdiv <= tdiv + 3'h1;
        timer_out <= tdiv[2];
    end

    utsbg_top u_utsbg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timer_out(timer_out), .serial_transmit_pin(line), .bit_clock(bclk));
    utsbg_line_peer #(.BIT_CYC(16)) u_utsbg_line_peer (.pclk(pclk), .line(line),
        .rx_data(rx_data), .rx_count(rx_count), .rx_err(rx_err));

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one apb transfer; entered just after a rising edge, leaves just after one
    task automatic apb(input logic [UTSBG_AW-1:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // read right after an edge: these are the values that edge sampled
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin n++; @(posedge pclk); end
        if (n == 20) begin
            $display("mismatch at %0t: no ready", $time);
            n_mismatch++;
            print_verdict();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    // poll status until it shows the wanted flags, bounded
    task automatic wait_status(input logic [7:0] e);
        int n;
        n = 0;
        apb(A_STAT, 1'b0, 8'h00);
        while (rdv[7:0] !== e && n < 300) begin n++; apb(A_STAT, 1'b0, 8'h00); end
        `CHK(rdv[7:0], e)
    endtask
    // cycles between two bit clock changes; rw repeats the writes mid half period
    task automatic bclk_gap(input logic [3:0] cs, input logic [7:0] k, input int e,
                            input logic rw);
        logic b;
        int   c;
        c = 0;
        if (!rw) begin
            // power and enables off while the divider is set up
            apb(A_MODE, 1'b1, 8'h00);
            apb(A_CKS, 1'b1, {4'h0, cs}); apb(A_DIV, 1'b1, k); apb(A_MODE, 1'b1, 8'h80);
        end
        @(negedge pclk); b = bclk;
        while (bclk === b && c < 20000) begin @(negedge pclk); c++; end
        b = bclk; c = 0;
        if (rw) begin
            // same values again, well inside the running half period
            @(posedge pclk); apb(A_DIV, 1'b1, k); apb(A_CKS, 1'b1, {4'h0, cs}); c = 6;
        end
        while (bclk === b && c < 20000) begin @(negedge pclk); c++; end
        `CHK(c, e)
        @(posedge pclk);
    endtask

    task automatic t_reset_values;
        `CHK(line, 1'b1)
        apb(A_STAT, 1'b0, 8'h00); `CHK(rdv, 32'h0)
        apb(A_CKS, 1'b0, 8'h00);  `CHK(rdv, 32'h0)
        apb(A_DIV, 1'b0, 8'h00);  `CHK(rdv, 32'hFF)
        apb(A_NONE, 1'b0, 8'h00); `CHK({err, rdv}, {1'b1, 32'h0})
        apb(A_STAT, 1'b1, 8'hFF); apb(A_STAT, 1'b0, 8'h00); `CHK({err, rdv}, 33'h0)
    endtask
    task automatic t_registers;
        apb(A_CKS, 1'b1, 8'hFF); apb(A_CKS, 1'b0, 8'h00); `CHK(rdv, 32'h0F)
        apb(A_DIV, 1'b1, 8'h5A); apb(A_DIV, 1'b0, 8'h00); `CHK(rdv, 32'h5A)
        apb(A_CKS, 1'b1, 8'h00); apb(A_DIV, 1'b1, 8'h08);
    endtask
    // two bytes back to back, second written once the buffer drains
    task automatic t_frames;
        apb(A_MODE, 1'b1, 8'h80); apb(A_MODE, 1'b1, 8'hC0);
        apb(A_TXB, 1'b1, 8'h5A);
        apb(A_STAT, 1'b0, 8'h00); `CHK(rdv[7:0], 8'h02)
        wait_status(8'h01);
        apb(A_TXB, 1'b1, 8'hC3);
        apb(A_STAT, 1'b0, 8'h00); `CHK(rdv[7:0], 8'h03)
        wait_status(8'h01);
        `CHK({rx_count, rx_data}, 16'h015A)
        wait_status(8'h00);
        `CHK({rx_err, rx_count, rx_data}, 17'h002C3)
    endtask
    // pending bytes dropped by enable and power; buffer writes ignored
    task automatic t_disable;
        apb(A_MODE, 1'b1, 8'h00); apb(A_MODE, 1'b1, 8'h80); apb(A_MODE, 1'b1, 8'hC0);
        apb(A_TXB, 1'b1, 8'h11); apb(A_MODE, 1'b1, 8'h80);
        apb(A_STAT, 1'b0, 8'h00); `CHK(rdv[7:0], 8'h00)
        apb(A_TXB, 1'b1, 8'h22);
        apb(A_STAT, 1'b0, 8'h00); `CHK(rdv[7:0], 8'h00)
        apb(A_MODE, 1'b1, 8'h00); apb(A_MODE, 1'b1, 8'h80); apb(A_MODE, 1'b1, 8'hC0);
        apb(A_TXB, 1'b1, 8'h33); apb(A_MODE, 1'b1, 8'h00);
        apb(A_STAT, 1'b0, 8'h00); `CHK(rdv[7:0], 8'h00)
        repeat (200) @(posedge pclk);
        `CHK({line, rx_count}, 9'h102)
    endtask
    // every clock source, both divisor ends, a same-value rewrite
    task automatic t_baud;
        for (int n = 0; n <= 10; n++) bclk_gap(n[3:0], 8'h08, 8 << n, 1'b0);
        bclk_gap(UTSBG_CKSEL_TIMER, 8'h08, 64, 1'b0);
        bclk_gap(4'h0, 8'hFF, 255, 1'b0);
        apb(A_MODE, 1'b1, 8'hC0);
        bclk_gap(4'h0, 8'hFF, 255, 1'b1);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_registers();
        t_frames();
        t_disable();
        t_baud();
        print_verdict();
    end
endmodule // test_uart_tx_status_and_baud_gen
`default_nettype wire
